// ==== hw/prs_pkg.sv ====
/*
 * prs_pkg: shared types and constants for the power resource sequencer.
 * assumes: consumers use prs_pkg::name, nothing is imported.
 */
package prs_pkg;

    // power mode walk of the whole chip
    typedef enum logic [2:0] {
        MODE_ACTIVE,
        MODE_DOZE,
        MODE_SAVE,
        MODE_DEEP_SLEEP,
        MODE_RESTORE,
        MODE_POWER_DOWN
    } prs_mode_t;

    // per-resource view: on flag and transition flag together
    typedef enum logic [1:0] {
        RES_DISABLED,
        RES_TRANS_ON,
        RES_ENABLED,
        RES_TRANS_OFF
    } prs_res_state_t;

    // chip-wide controls driven by the mode walk
    typedef struct packed {
        logic mainClockEnable;
        logic clockFast;
        logic regulatorsOn;
        logic coreRetainSave;
        logic coreRestore;
        logic coreResetHold;
        logic ioTristate;
        logic inputDisable;
    } prs_mode_ctrl_t;

    // oscillator, wake and power pin inputs, synchroniser bit positions
    localparam int SYNC_W = 5;
    localparam int SYNC_LPO = 0;
    localparam int SYNC_REG_ON = 1;
    localparam int SYNC_HIB = 2;
    localparam int SYNC_EXT_IRQ = 3;
    localparam int SYNC_USB_RESUME = 4;

    localparam logic PULL_DOWN_RST = 1'b1;
    localparam prs_mode_t MODE_RST = MODE_POWER_DOWN;
    localparam prs_mode_ctrl_t MODE_CTRL_RST = '{
        mainClockEnable: 1'b0,
        clockFast: 1'b0,
        regulatorsOn: 1'b0,
        coreRetainSave: 1'b0,
        coreRestore: 1'b0,
        coreResetHold: 1'b1,
        ioTristate: 1'b1,
        inputDisable: 1'b1
    };

endpackage

// ==== hw/pmu_resource_sequencer.sv ====
/*
 * pmu_resource_sequencer: resource request gathering, dependency closure,
 * per-resource on/off timers on low power oscillator ticks, and the chip
 * power mode walk (active, doze, deep-sleep with retention, power-down).
 * assumes: clk at 100 MHz; the oscillator, enable pin, hibernate input and
 * wake sources are asynchronous pins; core requests and controls are on clk.
 */
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// (RQ1) request is core clock requests, minimum mask and active request timers
// (RQ2) each core clock request maps to the resources making that clock
// (RQ3) each resource is enabled, disabled, turning on or turning off
// (RQ4) timer is zero when stable, nonzero while in transition
// (RQ5) timer loads on or off delay, counts down per oscillator tick
// (RQ6) timer at zero ends transition into enabled or disabled
// (RQ7) at zero clear transition flag and invert on flag
// (RQ8) zero enable delay means immediate disabled to enabled
// (RQ9) zero disable delay means immediate enabled to disabled
// (RQ10) required set recomputed each tick from requests and dependencies
// (RQ11) all nonzero timers decrement together each tick
// (RQ12) turn off only if enabled, unrequested, no powered dependents
// (RQ13) turn on only if disabled, requested, all dependencies enabled
// (RQ14) active mode: required regulators on, clock speed follows demand
// (RQ15) doze stops main clocks, oscillator keeps sequencer running
// (RQ16) core state saved before deep-sleep and restored after wake
// (RQ17) deep-sleep exit on request timer expiry, interrupt or usb resume
// (RQ18) power-down turns every regulator off until enable returns
// (RQ19) shutdown tristates outputs, disables inputs, retains nothing
// (RQ20) enable pin high means regulators on, low means reset and off
// (RQ21) enable pin pull-down on after reset, can be switched off
// (RQ22) low hibernate request disables regulators, mirrored to output
// (RQ23) resource count, timer width and dependency table are parameters
module pmu_resource_sequencer #(
    parameter int NUM_RES = 8,
    parameter int TIMER_W = 8,
    parameter int NUM_CORES = 2,
    parameter int RET_WORDS = 4,
    parameter int RET_W = 32,
    parameter logic [NUM_RES*NUM_RES-1:0] DEP_TABLE = '0,
    parameter logic [NUM_CORES*NUM_RES-1:0] CLK_MAP = '1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic lowPowerOscillator,
    input wire logic regulatorEnablePin,
    input wire logic hibernateRegulatorRequestIn,
    input wire logic extInterrupt,
    input wire logic usbResume,
    input wire logic [NUM_CORES-1:0] coreClockRequest,
    input wire logic [NUM_RES-1:0] minimumResourceMask,
    input wire logic [NUM_RES*TIMER_W-1:0] timeOn,
    input wire logic [NUM_RES*TIMER_W-1:0] timeOff,
    input wire logic reqTimerLoad,
    input wire logic [TIMER_W-1:0] reqTimerValue,
    input wire logic [NUM_RES-1:0] reqTimerMask,
    input wire logic dozeRequest,
    input wire logic deepSleepRequest,
    input wire logic pullDownDisable,
    input wire logic [RET_WORDS*RET_W-1:0] coreStateIn,
    output logic [NUM_RES-1:0] resourceOnFlag,
    output logic [NUM_RES-1:0] resourceTransitionFlag,
    output logic [NUM_RES-1:0] regulatorEnable,
    output prs_pkg::prs_mode_ctrl_t modeCtrl,
    output prs_pkg::prs_mode_t powerMode,
    output logic hibernateRegulatorRequestOut,
    output logic pullDownEnable,
    output logic [RET_WORDS*RET_W-1:0] coreStateOut
);

    // RQ23
    if (NUM_RES < 1 || TIMER_W < 1 || NUM_CORES < 1 || RET_WORDS < 1 || RET_W < 1) begin
        $error("pmu_resource_sequencer: parameters must all be at least one");
    end

    // a resource needing itself could never start, so refuse such a table
    for (genvar d = 0; d < NUM_RES; d++) begin : gSelfDep
        if (DEP_TABLE[d*NUM_RES + d]) begin
            $error("pmu_resource_sequencer: a resource cannot depend on itself");
        end
    end

    logic [prs_pkg::SYNC_W-1:0] syncA_reg;
    logic [prs_pkg::SYNC_W-1:0] syncB_reg;
    logic lpoPrev_reg;
    logic tick;
    logic powerOk;
    logic wake;
    logic [TIMER_W-1:0] reqTimer_reg;
    logic reqTimerExpire;
    logic [NUM_RES-1:0] baseReq;
    logic [NUM_RES-1:0] required;
    logic [NUM_RES-1:0] stableOn;
    logic [NUM_RES-1:0] powered;
    logic [NUM_RES-1:0] onFlag_reg;
    logic [NUM_RES-1:0] pending_reg;
    logic [TIMER_W-1:0] timer_reg [NUM_RES];
    logic [RET_W-1:0] retainMem_reg [RET_WORDS];
    prs_pkg::prs_mode_t mode_reg;
    prs_pkg::prs_mode_t mode_next;
    prs_pkg::prs_mode_ctrl_t ctrl_next;

    // only the second stage is read by logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
            lpoPrev_reg <= 1'b0;
        end else begin
            syncA_reg <= {usbResume, extInterrupt, hibernateRegulatorRequestIn,
                          regulatorEnablePin, lowPowerOscillator};
            syncB_reg <= syncA_reg;
            lpoPrev_reg <= syncB_reg[prs_pkg::SYNC_LPO];
        end
    end

    // one sequencer step per rising oscillator edge
    assign tick = syncB_reg[prs_pkg::SYNC_LPO] & ~lpoPrev_reg; // RQ5
    // RQ20 RQ22
    assign powerOk = syncB_reg[prs_pkg::SYNC_REG_ON] & syncB_reg[prs_pkg::SYNC_HIB];

    // resource request timer, counted on sequencer ticks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reqTimer_reg <= '0;
        end else if (!powerOk) begin
            reqTimer_reg <= '0;
        end else if (reqTimerLoad) begin
            reqTimer_reg <= reqTimerValue;
        end else if (tick && reqTimer_reg != '0) begin
            reqTimer_reg <= reqTimer_reg - 1'b1;
        end
    end
    assign reqTimerExpire = tick && reqTimer_reg == {{(TIMER_W-1){1'b0}}, 1'b1};

    // closure over the dependency table; resource i needs the bits of row i
    function automatic logic [NUM_RES-1:0] closeDeps(input logic [NUM_RES-1:0] req);
        logic [NUM_RES-1:0] acc;
        acc = req;
        for (int pass = 0; pass < NUM_RES; pass++) begin
            for (int i = 0; i < NUM_RES; i++) begin
                if (acc[i]) begin
                    acc = acc | DEP_TABLE[i*NUM_RES +: NUM_RES];
                end
            end
        end
        return acc;
    endfunction

    always_comb begin
        baseReq = minimumResourceMask; // RQ1
        if (reqTimer_reg != '0) begin
            baseReq = baseReq | reqTimerMask; // RQ1
        end
        for (int c = 0; c < NUM_CORES; c++) begin
            if (coreClockRequest[c]) begin
                baseReq = baseReq | CLK_MAP[c*NUM_RES +: NUM_RES]; // RQ2
            end
        end
    end

    assign required = closeDeps(baseReq); // RQ10
    assign stableOn = onFlag_reg & ~pending_reg;
    assign powered = onFlag_reg | pending_reg;

    // per-resource walk: on flag and transition flag encode the four states
    for (genvar r = 0; r < NUM_RES; r++) begin : gRes
        logic [NUM_RES-1:0] dependents;
        logic [TIMER_W-1:0] onDelay;
        logic [TIMER_W-1:0] offDelay;

        always_comb begin
            dependents = '0;
            for (int j = 0; j < NUM_RES; j++) begin
                dependents[j] = DEP_TABLE[j*NUM_RES + r];
            end
        end
        assign onDelay = timeOn[r*TIMER_W +: TIMER_W];
        assign offDelay = timeOff[r*TIMER_W +: TIMER_W];

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                onFlag_reg[r] <= 1'b0;
                pending_reg[r] <= 1'b0;
                timer_reg[r] <= '0;
            end else if (!powerOk) begin
                // held in reset: nothing survives the low enable
                onFlag_reg[r] <= 1'b0; // RQ20
                pending_reg[r] <= 1'b0;
                timer_reg[r] <= '0;
            end else if (tick) begin
                if (timer_reg[r] != '0) begin // RQ3
                    timer_reg[r] <= timer_reg[r] - 1'b1; // RQ11
                    if (timer_reg[r] == {{(TIMER_W-1){1'b0}}, 1'b1}) begin
                        pending_reg[r] <= 1'b0; // RQ6 RQ7
                        onFlag_reg[r] <= ~onFlag_reg[r]; // RQ7
                    end
                end else if (!onFlag_reg[r] && !pending_reg[r] && required[r]
                             && (DEP_TABLE[r*NUM_RES +: NUM_RES] & ~stableOn) == '0) begin // RQ13
                    if (onDelay == '0) begin
                        onFlag_reg[r] <= 1'b1; // RQ8
                    end else begin
                        timer_reg[r] <= onDelay; // RQ5 RQ4
                        pending_reg[r] <= 1'b1;
                    end
                end else if (stableOn[r] && !required[r]
                             && (dependents & powered) == '0) begin // RQ12
                    if (offDelay == '0) begin
                        onFlag_reg[r] <= 1'b0; // RQ9
                    end else begin
                        timer_reg[r] <= offDelay; // RQ5 RQ4
                        pending_reg[r] <= 1'b1;
                    end
                end
            end
        end
    end

    // deep-sleep exit sources
    assign wake = reqTimerExpire | syncB_reg[prs_pkg::SYNC_EXT_IRQ]
                  | syncB_reg[prs_pkg::SYNC_USB_RESUME]; // RQ17

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            prs_pkg::MODE_ACTIVE: begin
                if (dozeRequest) begin
                    mode_next = prs_pkg::MODE_DOZE;
                end else if (deepSleepRequest) begin
                    mode_next = prs_pkg::MODE_SAVE; // RQ16
                end
            end
            prs_pkg::MODE_DOZE: begin
                if (wake) begin
                    mode_next = prs_pkg::MODE_ACTIVE; // RQ15
                end
            end
            prs_pkg::MODE_SAVE: begin
                mode_next = prs_pkg::MODE_DEEP_SLEEP;
            end
            prs_pkg::MODE_DEEP_SLEEP: begin
                if (wake) begin
                    mode_next = prs_pkg::MODE_RESTORE; // RQ17
                end
            end
            prs_pkg::MODE_RESTORE: begin
                mode_next = prs_pkg::MODE_ACTIVE;
            end
            prs_pkg::MODE_POWER_DOWN: begin
                mode_next = prs_pkg::MODE_ACTIVE; // RQ18
            end
            default: begin
                mode_next = prs_pkg::MODE_POWER_DOWN;
            end
        endcase
        if (!powerOk) begin
            mode_next = prs_pkg::MODE_POWER_DOWN; // RQ18 RQ22
        end
    end

    always_comb begin
        ctrl_next.mainClockEnable = mode_next == prs_pkg::MODE_ACTIVE
                                    || mode_next == prs_pkg::MODE_SAVE
                                    || mode_next == prs_pkg::MODE_RESTORE; // RQ15
        ctrl_next.clockFast = mode_next == prs_pkg::MODE_ACTIVE && coreClockRequest != '0; // RQ14
        ctrl_next.regulatorsOn = mode_next != prs_pkg::MODE_POWER_DOWN; // RQ18
        ctrl_next.coreRetainSave = mode_next == prs_pkg::MODE_SAVE; // RQ16
        ctrl_next.coreRestore = mode_next == prs_pkg::MODE_RESTORE; // RQ16
        ctrl_next.coreResetHold = mode_next == prs_pkg::MODE_POWER_DOWN; // RQ20
        ctrl_next.ioTristate = mode_next == prs_pkg::MODE_POWER_DOWN; // RQ19
        ctrl_next.inputDisable = mode_next == prs_pkg::MODE_POWER_DOWN; // RQ19
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= prs_pkg::MODE_RST;
            powerMode <= prs_pkg::MODE_RST;
            modeCtrl <= prs_pkg::MODE_CTRL_RST;
        end else begin
            mode_reg <= mode_next;
            powerMode <= mode_next;
            modeCtrl <= ctrl_next;
        end
    end

    // retention lives in the always-on domain; power-down wipes it anyway
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int w = 0; w < RET_WORDS; w++) begin
                retainMem_reg[w] <= '0;
            end
            coreStateOut <= '0;
        end else if (!powerOk) begin
            for (int w = 0; w < RET_WORDS; w++) begin
                retainMem_reg[w] <= '0; // RQ19
            end
            coreStateOut <= '0;
        end else if (mode_reg == prs_pkg::MODE_ACTIVE && mode_next == prs_pkg::MODE_SAVE) begin
            for (int w = 0; w < RET_WORDS; w++) begin
                retainMem_reg[w] <= coreStateIn[w*RET_W +: RET_W]; // RQ16
            end
        end else if (mode_next == prs_pkg::MODE_RESTORE) begin
            for (int w = 0; w < RET_WORDS; w++) begin
                coreStateOut[w*RET_W +: RET_W] <= retainMem_reg[w]; // RQ16
            end
        end
    end

    // status flags trail the internal walk by one clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resourceOnFlag <= '0;
            resourceTransitionFlag <= '0;
        end else begin
            resourceOnFlag <= onFlag_reg;
            resourceTransitionFlag <= pending_reg;
        end
    end

    // gated by power too, so a low enable drops them without waiting for a tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regulatorEnable <= '0;
        end else begin
            regulatorEnable <= powerOk ? onFlag_reg : '0; // RQ14 RQ20 RQ22
        end
    end

    // mirrored for the external loop back onto the enable pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hibernateRegulatorRequestOut <= 1'b0;
        end else begin
            hibernateRegulatorRequestOut <= syncB_reg[prs_pkg::SYNC_HIB]; // RQ22
        end
    end

    // pull-down on out of reset; a control level may switch it off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pullDownEnable <= prs_pkg::PULL_DOWN_RST;
        end else begin
            pullDownEnable <= ~pullDownDisable; // RQ21
        end
    end

endmodule

`default_nettype wire

// ==== verif/prs_assertions.sv ====
/* prs_assertions: port checks on the sequencer.
   assumes: bound to the top; resource 1 depends on resource 0. */
`timescale 1ns/1ns
`default_nettype none
module prs_assertions #(
    parameter int NUM_RES = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic regulatorEnablePin,
    input wire logic hibernateRegulatorRequestIn,
    input wire logic pullDownDisable,
    input wire logic [NUM_RES-1:0] resourceOnFlag,
    input wire logic [NUM_RES-1:0] resourceTransitionFlag,
    input wire logic [NUM_RES-1:0] regulatorEnable,
    input wire prs_pkg::prs_mode_ctrl_t modeCtrl,
    input wire prs_pkg::prs_mode_t powerMode,
    input wire logic pullDownEnable
);
    // pins must settle through sync before flag rules apply
    wire pinOk = regulatorEnablePin && hibernateRegulatorRequestIn;
    wire res0On = resourceOnFlag[0] && !resourceTransitionFlag[0];
    wire res1Up = resourceOnFlag[1] || resourceTransitionFlag[1];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_pin_off;
        !regulatorEnablePin [*5] |-> regulatorEnable == '0 && powerMode == prs_pkg::MODE_POWER_DOWN;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("enable pin low, power on");
    property p_hib_off;
        !hibernateRegulatorRequestIn [*5] |-> regulatorEnable == '0;
    endproperty
    a_hib_off: assert property (p_hib_off) else $error("hibernate low, power on");
    property p_pull;
        $stable(pullDownDisable) [*3] |-> pullDownEnable == !pullDownDisable;
    endproperty
    a_pull: assert property (p_pull) else $error("pull-down control wrong");
    property p_flip;
        pinOk [*6] |-> (($past(resourceTransitionFlag) & ~resourceTransitionFlag)
            & ~($past(resourceOnFlag) ^ resourceOnFlag)) == '0;
    endproperty
    a_flip: assert property (p_flip) else $error("transition ended without flip");
    property p_dep_on;
        pinOk [*6] ##0 $rose(res1Up) |-> res0On;
    endproperty
    a_dep_on: assert property (p_dep_on) else $error("started before dependency");
    property p_dep_off;
        pinOk [*6] ##0 $fell(res0On) |-> !res1Up;
    endproperty
    a_dep_off: assert property (p_dep_off) else $error("stopped under dependent");
    property p_save;
        pinOk [*6] ##0 powerMode == prs_pkg::MODE_SAVE
            |-> modeCtrl.coreRetainSave ##1 powerMode == prs_pkg::MODE_DEEP_SLEEP;
    endproperty
    a_save: assert property (p_save) else $error("save step wrong");
    property p_pdown;
        powerMode == prs_pkg::MODE_POWER_DOWN
            |-> modeCtrl.ioTristate && modeCtrl.inputDisable && regulatorEnable == '0;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down outputs wrong");
    property p_restore;
        pinOk [*6] ##0 powerMode == prs_pkg::MODE_RESTORE
            |-> modeCtrl.coreRestore ##1 powerMode == prs_pkg::MODE_ACTIVE;
    endproperty
    a_restore: assert property (p_restore) else $error("restore step wrong");
    property p_regs_on;
        powerMode != prs_pkg::MODE_POWER_DOWN
            |-> modeCtrl.regulatorsOn && !modeCtrl.coreResetHold;
    endproperty
    a_regs_on: assert property (p_regs_on) else $error("powered mode without regulators");
    c_deep: cover property (powerMode == prs_pkg::MODE_DEEP_SLEEP);
    c_doze: cover property (powerMode == prs_pkg::MODE_DOZE);
    c_dep: cover property (res0On && res1Up);
endmodule
`default_nettype wire

// ==== verif/prs_far_side.sv ====
/* prs_far_side: host logic at the enable pin and the slow oscillator.
   assumes: oscillator runs free; hibTie closes the hibernate loop. */
`timescale 1ns/1ns
`default_nettype none
module prs_far_side #(
    parameter int HALF_NS = 15259
) (
    input wire logic hostEnable,
    input wire logic hibTie,
    input wire logic hibernateRegulatorRequestOut,
    output logic lowPowerOscillator,
    output logic regulatorEnablePin
);
    initial lowPowerOscillator = 1'b0;
    always #(HALF_NS) lowPowerOscillator = ~lowPowerOscillator;
    // hibernate drops the regulators without the loop; with it the mirror also pulls the enable pin low
    assign regulatorEnablePin = hibTie ? hibernateRegulatorRequestOut : hostEnable;
endmodule
`default_nettype wire

// ==== verif/pmu_resource_sequencer_tb.sv ====
/* pmu_resource_sequencer_tb: directed tests at the sequencer pins.
   assumes: resource 1 needs resource 0; oscillator shortened to 200 ns. */
`timescale 1ns/1ns
`default_nettype none
module pmu_resource_sequencer_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hostEnable = 1'b0;
    logic hibTie = 1'b0;
    logic hibIn = 1'b1;
    logic extIrq = 1'b0;
    logic usbRes = 1'b0;
    logic [1:0] coreReq = '0;
    logic [3:0] minMask = '0;
    logic tLoad = 1'b0;
    logic [3:0] tValue = '0;
    logic [3:0] tMask = '0;
    logic doze = 1'b0;
    logic deep = 1'b0;
    logic pdDis = 1'b0;
    logic [127:0] stateIn = '0;
    logic [15:0] tOn = 16'h1302;
    logic [15:0] tOff = 16'h1021;
    logic low_power_oscillator;
    logic pin;
    logic [3:0] onFlag;
    logic [3:0] trFlag;
    logic [3:0] regEn;
    prs_pkg::prs_mode_ctrl_t ctrl;
    prs_pkg::prs_mode_t mode;
    logic hibOut;
    logic pdEn;
    logic [127:0] stateOut;
    int miscompares = 0;
    int total_checks = 0;
    always #5 clk = ~clk;
    prs_far_side #(.HALF_NS(100)) u_prs_far_side (.hostEnable(hostEnable), .hibTie(hibTie),
        .hibernateRegulatorRequestOut(hibOut), .lowPowerOscillator(low_power_oscillator), .regulatorEnablePin(pin));
    pmu_resource_sequencer #(.NUM_RES(4), .TIMER_W(4), .DEP_TABLE(16'h0010), .CLK_MAP(8'h84))
    u_pmu_resource_sequencer (.clk(clk), .rst(rst), .lowPowerOscillator(low_power_oscillator),
        .regulatorEnablePin(pin), .hibernateRegulatorRequestIn(hibIn), .extInterrupt(extIrq),
        .usbResume(usbRes), .coreClockRequest(coreReq), .minimumResourceMask(minMask),
        .timeOn(tOn), .timeOff(tOff), .reqTimerLoad(tLoad), .reqTimerValue(tValue),
        .reqTimerMask(tMask), .dozeRequest(doze), .deepSleepRequest(deep),
        .pullDownDisable(pdDis), .coreStateIn(stateIn), .resourceOnFlag(onFlag),
        .resourceTransitionFlag(trFlag), .regulatorEnable(regEn), .modeCtrl(ctrl),
        .powerMode(mode), .hibernateRegulatorRequestOut(hibOut), .pullDownEnable(pdEn),
        .coreStateOut(stateOut));
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // settle after a tick: two sync flops, flags, output register
    task automatic tick(input int n);
        repeat (n) @(posedge low_power_oscillator);
        step(6);
    endtask
    task automatic flags(input logic [3:0] on, input logic [3:0] tr);
        check({trFlag, onFlag}, {tr, on});
    endtask
    task automatic wait_mode(input prs_pkg::prs_mode_t m);
        int n;
        n = 0;
        while (mode !== m && n < 300) begin
            step(1);
            n++;
        end
        check(mode, m);
    endtask
    task automatic test_done();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        test_done();
    end
    initial begin
        step(2);
        check(mode, prs_pkg::MODE_RST);
        check(ctrl, prs_pkg::MODE_CTRL_RST);
        check({pdEn, regEn, onFlag, trFlag}, {1'b1, 12'h000});
        rst = 1'b0;
        step(3);
        check(mode, prs_pkg::MODE_POWER_DOWN);
        hostEnable = 1'b1;
        wait_mode(prs_pkg::MODE_ACTIVE);
        minMask = 4'h3;
        tick(1);
        flags(4'h0, 4'h1);
        tick(1);
        flags(4'h0, 4'h1);
        tick(1);
        check({trFlag[0], onFlag[0]}, 2'b01);
        tick(1);
        flags(4'h3, 4'h0);
        check(regEn, 4'h3);
        coreReq = 2'b11;
        tick(1);
        flags(4'h3, 4'hc);
        check(ctrl.clockFast, 1'b1);
        tick(1);
        flags(4'hb, 4'h4);
        tick(2);
        flags(4'hf, 4'h0);
        coreReq = 2'b00;
        minMask = 4'h0;
        tick(1);
        flags(4'hb, 4'ha);
        tick(1);
        flags(4'h3, 4'h2);
        tick(1);
        flags(4'h1, 4'h0);
        tick(2);
        flags(4'h0, 4'h0);
        tValue = 4'h3;
        tMask = 4'h8;
        tLoad = 1'b1;
        step(1);
        tLoad = 1'b0;
        tick(2);
        flags(4'h8, 4'h0);
        tick(4);
        flags(4'h0, 4'h0);
        doze = 1'b1;
        wait_mode(prs_pkg::MODE_DOZE);
        doze = 1'b0;
        check(ctrl.mainClockEnable, 1'b0);
        extIrq = 1'b1;
        wait_mode(prs_pkg::MODE_ACTIVE);
        extIrq = 1'b0;
        step(4);
        // one pass per wake source: timer, interrupt, usb resume
        for (int w = 0; w < 3; w++) begin
            stateIn = {32{4'(w + 1)}};
            tValue = 4'h4;
            tMask = 4'h0;
            tLoad = (w == 0);
            step(1);
            tLoad = 1'b0;
            deep = 1'b1;
            wait_mode(prs_pkg::MODE_SAVE);
            deep = 1'b0;
            wait_mode(prs_pkg::MODE_DEEP_SLEEP);
            check(ctrl.mainClockEnable, 1'b0);
            stateIn = '0;
            extIrq = (w == 1);
            usbRes = (w == 2);
            wait_mode(prs_pkg::MODE_ACTIVE);
            check(stateOut, {32{4'(w + 1)}});
            extIrq = 1'b0;
            usbRes = 1'b0;
            step(4);
        end
        minMask = 4'h1;
        tick(4);
        hibTie = 1'b1;
        hibIn = 1'b0;
        wait_mode(prs_pkg::MODE_POWER_DOWN);
        step(2);
        check({regEn, onFlag, ctrl.ioTristate, ctrl.inputDisable}, 10'h003);
        check(ctrl, prs_pkg::MODE_CTRL_RST);
        check(hibOut, 1'b0);
        hibIn = 1'b1;
        wait_mode(prs_pkg::MODE_ACTIVE);
        hibTie = 1'b0;
        tick(1);
        flags(4'h0, 4'h1);
        hostEnable = 1'b0;
        wait_mode(prs_pkg::MODE_POWER_DOWN);
        check(regEn, 4'h0);
        pdDis = 1'b1;
        step(2);
        check(pdEn, 1'b0);
        pdDis = 1'b0;
        step(2);
        check(pdEn, 1'b1);
        // longer on delay for resource 0; align so no tick lands during power-up
        tOn = 16'h1304;
        tick(1);
        hostEnable = 1'b1;
        wait_mode(prs_pkg::MODE_ACTIVE);
        tick(4);
        flags(4'h0, 4'h1);
        tick(1);
        flags(4'h1, 4'h0);
        check(regEn, 4'h1);
        test_done();
    end
endmodule
bind pmu_resource_sequencer prs_assertions #(.NUM_RES(NUM_RES)) u_prs_assertions (.clk(clk),
    .rst(rst), .regulatorEnablePin(regulatorEnablePin),
    .hibernateRegulatorRequestIn(hibernateRegulatorRequestIn),
    .pullDownDisable(pullDownDisable), .resourceOnFlag(resourceOnFlag),
    .resourceTransitionFlag(resourceTransitionFlag), .regulatorEnable(regulatorEnable),
    .modeCtrl(modeCtrl), .powerMode(powerMode), .pullDownEnable(pullDownEnable));
`default_nettype wire
